// ==== core/rpc_pkg.sv ====
// Package of constants and types for the remote port configuration block
package rpc_pkg;

  // ==========================================================================
  // Command codes delivered by the text parser
  typedef enum logic [3:0] {
    OP_QMASK_WR,
    OP_QMASK_RD,
    OP_QEVT_RD,
    OP_ADDR_WR,
    OP_ADDR_RD,
    OP_RATE_WR,
    OP_RATE_RD,
    OP_ECHO_WR,
    OP_ECHO_RD,
    OP_PACE_WR,
    OP_PACE_RD,
    OP_PROMPT_WR,
    OP_PROMPT_RD,
    OP_SAVE,
    OP_INST_RST
  } rpc_op_t;

  // ==========================================================================
  // Status layout
  localparam int          QSUM_BIT     = 3;
  localparam logic [15:0] QEVT_LATCHED = 16'h3000;
  localparam logic [15:0] QEVT_LIVE    = 16'h0003;
  localparam logic [15:0] QMASK_RST    = 16'h0000;

  // ==========================================================================
  // Bus address
  localparam logic [4:0]  ADDR_MAX     = 5'h1E;
  localparam logic [4:0]  ADDR_RST     = 5'h06;

  // ==========================================================================
  // Serial rate codes and their values
  localparam logic [1:0]  RATE_19200   = 2'h0;
  localparam logic [1:0]  RATE_9600    = 2'h1;
  localparam logic [1:0]  RATE_4800    = 2'h2;
  localparam logic [1:0]  RATE_2400    = 2'h3;
  localparam logic [15:0] BAUD_19200   = 16'h4B00;
  localparam logic [15:0] BAUD_9600    = 16'h2580;
  localparam logic [15:0] BAUD_4800    = 16'h12C0;
  localparam logic [15:0] BAUD_2400    = 16'h0960;
  localparam logic [1:0]  RATE_RST     = RATE_19200;

  // ==========================================================================
  // Characters
  localparam logic [7:0]  CHR_TERM     = 8'h0A;
  localparam logic [7:0]  CHR_PROMPT   = 8'h3E;
  localparam logic [7:0]  CHR_XON      = 8'h11;
  localparam logic [7:0]  CHR_XOFF     = 8'h13;

  // ==========================================================================
  // Reset values of the port settings, and the transmit buffer depth
  localparam logic        ECHO_RST     = 1'b0;
  localparam logic        PACE_RST     = 1'b0;
  localparam logic        PROMPT_RST   = 1'b0;
  localparam logic [1:0]  BUF_DEPTH    = 2'h2;

endpackage

// ==== core/rpc_core.sv ====
// Command handling core for the remote ports and the questionable mask
`timescale 1ns/100ps
`default_nettype none

module rpc_core (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             cmd_valid,
  input  wire rpc_pkg::rpc_op_t cmd_op,
  input  wire logic [15:0]      cmd_arg,
  input  wire logic             cmd_parsed,
  output logic                  rsp_valid,
  output logic [15:0]           rsp_data,
  output logic                  cmd_err,
  input  wire logic [15:0]      ques_cond,
  output logic                  ques_summary,
  input  wire logic [4:0]       saved_addr,
  output logic [4:0]            bus_addr,
  output logic                  save_req,
  output logic [1:0]            rate_sel,
  output logic                  echo_on,
  output logic                  pace_on,
  output logic                  prompt_on,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_data,
  output logic                  rx_ready,
  input  wire logic             rx_near_full,
  input  wire logic             tx_idle,
  output logic                  tx_valid,
  output logic [7:0]            tx_data,
  input  wire logic             tx_ready
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic            init;
    logic [15:0]     mask;
    logic [15:0]     qevt;
    logic [4:0]      addr;
    logic [1:0]      rate;
    logic            rate_pend;
    logic [1:0]      rate_next;
    logic            echo;
    logic            echo_stop;
    logic            pace;
    logic            xoff_sent;
    logic            flow_pend;
    logic [7:0]      flow_char;
    logic            prompt;
    logic            prompt_pend;
    logic            rsp_v;
    logic [15:0]     rsp_d;
    logic            err;
    logic            save;
    logic [1:0][7:0] mem;
    logic [1:0]      cnt;
    logic            rd;
  } rpc_state_t;

  rpc_state_t s_q;
  rpc_state_t s_d;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] rate_code(input logic [15:0] v);
    unique case (v)
      rpc_pkg::BAUD_19200: rate_code = {1'b1, rpc_pkg::RATE_19200};
      rpc_pkg::BAUD_9600:  rate_code = {1'b1, rpc_pkg::RATE_9600};
      rpc_pkg::BAUD_4800:  rate_code = {1'b1, rpc_pkg::RATE_4800};
      rpc_pkg::BAUD_2400:  rate_code = {1'b1, rpc_pkg::RATE_2400};
      default:             rate_code = 3'h0;
    endcase
  endfunction

  function automatic logic [15:0] rate_value(input logic [1:0] c);
    unique case (c)
      rpc_pkg::RATE_19200: rate_value = rpc_pkg::BAUD_19200;
      rpc_pkg::RATE_9600:  rate_value = rpc_pkg::BAUD_9600;
      rpc_pkg::RATE_4800:  rate_value = rpc_pkg::BAUD_4800;
      rpc_pkg::RATE_2400:  rate_value = rpc_pkg::BAUD_2400;
    endcase
  endfunction

  function automatic logic is_bool(input logic [15:0] v);
    is_bool = (v[15:1] == 15'h0000);
  endfunction

  // ==========================================================================
  // Transmit path arbitration
  logic        in_ready;
  logic        flow_go;
  logic        echo_go;
  logic        prompt_go;
  logic        push;
  logic        pop;
  logic [7:0]  push_char;
  logic        rx_take;
  logic [15:0] qevt_view;
  logic [2:0]  rc;

  // Flow characters first: a late XOFF lets the receive buffer overflow
  assign in_ready  = (s_q.cnt != rpc_pkg::BUF_DEPTH);
  assign flow_go   = s_q.flow_pend;
  assign echo_go   = rx_valid && s_q.echo && !s_q.flow_pend;
  assign prompt_go = s_q.prompt_pend && !s_q.flow_pend && !echo_go;
  assign push      = (flow_go || echo_go || prompt_go) && in_ready;
  assign pop       = tx_valid && tx_ready;
  assign push_char = flow_go ? s_q.flow_char : (echo_go ? rx_data : rpc_pkg::CHR_PROMPT);
  // A stalled transmitter holds off receive while echo is on, losing nothing
  assign rx_ready  = !s_q.echo || (in_ready && !s_q.flow_pend);
  assign rx_take   = rx_valid && rx_ready;
  assign qevt_view = s_q.qevt | (ques_cond & rpc_pkg::QEVT_LIVE);
  assign rc        = rate_code(cmd_arg);

  // ==========================================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.rsp_v = 1'b0;
    s_d.err   = 1'b0;
    s_d.save  = 1'b0;

    // Saved address is taken once, just after reset release
    if (!s_q.init) begin
      s_d.init = 1'b1;
      s_d.addr = (saved_addr > rpc_pkg::ADDR_MAX) ? rpc_pkg::ADDR_RST : saved_addr;
    end

    s_d.qevt = s_q.qevt | (ques_cond & rpc_pkg::QEVT_LATCHED);

    // Rate switch only when nothing is queued or on the wire; decided before the
    // command decode so that a rate request in the same cycle stays pending
    if (s_q.rate_pend && tx_idle && s_q.cnt == 2'h0 && !s_q.flow_pend && !s_q.prompt_pend) begin
      s_d.rate      = s_q.rate_next;
      s_d.rate_pend = 1'b0;
    end

    if (cmd_valid) begin
      unique case (cmd_op)
        rpc_pkg::OP_QMASK_WR: s_d.mask = cmd_arg;
        rpc_pkg::OP_QMASK_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = s_q.mask;
        end
        rpc_pkg::OP_QEVT_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = qevt_view;
          // Clear, but a bit arriving in the same cycle survives
          s_d.qevt  = ques_cond & rpc_pkg::QEVT_LATCHED;
        end
        rpc_pkg::OP_ADDR_WR: begin
          if (cmd_arg <= {11'h000, rpc_pkg::ADDR_MAX}) begin
            s_d.addr = cmd_arg[4:0];
          end else begin
            s_d.err = 1'b1;
          end
        end
        rpc_pkg::OP_ADDR_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = {11'h000, s_q.addr};
        end
        rpc_pkg::OP_RATE_WR: begin
          if (rc[2]) begin
            s_d.rate_pend = 1'b1;
            s_d.rate_next = rc[1:0];
          end else begin
            s_d.err = 1'b1;
          end
        end
        rpc_pkg::OP_RATE_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = rate_value(s_q.rate);
        end
        rpc_pkg::OP_ECHO_WR: begin
          if (!is_bool(cmd_arg)) begin
            s_d.err = 1'b1;
          end else if (cmd_arg[0]) begin
            s_d.echo      = 1'b1;
            s_d.echo_stop = 1'b0;
          end else begin
            s_d.echo_stop = s_q.echo;
          end
        end
        rpc_pkg::OP_ECHO_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = {15'h0000, s_q.echo};
        end
        rpc_pkg::OP_PACE_WR: begin
          if (is_bool(cmd_arg)) begin
            s_d.pace = cmd_arg[0];
          end else begin
            s_d.err = 1'b1;
          end
        end
        rpc_pkg::OP_PACE_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = {15'h0000, s_q.pace};
        end
        rpc_pkg::OP_PROMPT_WR: begin
          if (is_bool(cmd_arg)) begin
            s_d.prompt = cmd_arg[0];
          end else begin
            s_d.err = 1'b1;
          end
        end
        rpc_pkg::OP_PROMPT_RD: begin
          s_d.rsp_v = 1'b1;
          s_d.rsp_d = {15'h0000, s_q.prompt};
        end
        rpc_pkg::OP_SAVE: s_d.save = 1'b1;
        rpc_pkg::OP_INST_RST: s_d.mask = s_q.mask;
        default: s_d.err = 1'b1;
      endcase
    end

    // Echo ends only once the terminator itself has gone back
    if (rx_take && s_q.echo_stop && rx_data == rpc_pkg::CHR_TERM) begin
      s_d.echo      = 1'b0;
      s_d.echo_stop = 1'b0;
    end

    // Flow control handshakes
    if (flow_go && in_ready) begin
      s_d.flow_pend = 1'b0;
    end
    if (!s_q.pace) begin
      s_d.xoff_sent = 1'b0;
    end else if (!s_q.flow_pend && rx_near_full && !s_q.xoff_sent) begin
      s_d.flow_pend = 1'b1;
      s_d.flow_char = rpc_pkg::CHR_XOFF;
      s_d.xoff_sent = 1'b1;
    end else if (!s_q.flow_pend && !rx_near_full && s_q.xoff_sent) begin
      s_d.flow_pend = 1'b1;
      s_d.flow_char = rpc_pkg::CHR_XON;
      s_d.xoff_sent = 1'b0;
    end

    // Prompt request: a new parse wins over the send of the previous one
    if (prompt_go && in_ready) begin
      s_d.prompt_pend = 1'b0;
    end
    if (cmd_parsed && s_q.prompt) begin
      s_d.prompt_pend = 1'b1;
    end

    // Two-entry transmit buffer
    if (push) begin
      s_d.mem[s_q.rd ^ s_q.cnt[0]] = push_char;
    end
    if (pop) begin
      s_d.rd = !s_q.rd;
    end
    s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q             <= '0;
      s_q.mask        <= rpc_pkg::QMASK_RST;
      s_q.addr        <= rpc_pkg::ADDR_RST;
      s_q.rate        <= rpc_pkg::RATE_RST;
      s_q.rate_next   <= rpc_pkg::RATE_RST;
      s_q.echo        <= rpc_pkg::ECHO_RST;
      s_q.pace        <= rpc_pkg::PACE_RST;
      s_q.prompt      <= rpc_pkg::PROMPT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign rsp_valid    = s_q.rsp_v;
  assign rsp_data     = s_q.rsp_d;
  assign cmd_err      = s_q.err;
  assign ques_summary = |(qevt_view & s_q.mask);
  assign bus_addr     = s_q.addr;
  assign save_req     = s_q.save;
  assign rate_sel     = s_q.rate;
  assign echo_on      = s_q.echo;
  assign pace_on      = s_q.pace;
  assign prompt_on    = s_q.prompt;
  assign tx_valid     = (s_q.cnt != 2'h0);
  assign tx_data      = s_q.mem[s_q.rd];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_echo_off_cmd;
    cmd_valid && cmd_op == rpc_pkg::OP_ECHO_WR && cmd_arg == 16'h0000 && echo_on;
  endsequence

  sequence s_term_taken;
    rx_take && rx_data == rpc_pkg::CHR_TERM;
  endsequence

  AST_SUMMARY: assert property (ques_summary |-> (s_q.mask & qevt_view) != 16'h0000)
    else $error("summary set without an enabled event");
  AST_MASK_WR: assert property (cmd_valid && cmd_op == rpc_pkg::OP_QMASK_WR
    |=> s_q.mask == $past(cmd_arg))
    else $error("mask write not stored");
  AST_MASK_RD: assert property (cmd_valid && cmd_op == rpc_pkg::OP_QMASK_RD
    |=> rsp_valid && rsp_data == $past(s_q.mask))
    else $error("mask query answer wrong");
  AST_ADDR_RANGE: assert property (s_q.init |-> bus_addr <= rpc_pkg::ADDR_MAX)
    else $error("bus address above range");
  AST_ADDR_RD: assert property (cmd_valid && cmd_op == rpc_pkg::OP_ADDR_RD
    |=> rsp_valid && rsp_data == {11'h000, $past(bus_addr)})
    else $error("address query answer wrong");
  AST_RATE_RD: assert property (cmd_valid && cmd_op == rpc_pkg::OP_RATE_RD
    |=> rsp_data == rate_value($past(rate_sel)))
    else $error("rate query answer wrong");
  AST_RATE_HOLD: assert property (tx_valid |=> $stable(rate_sel))
    else $error("rate changed while characters queued");
  AST_ECHO_OFF: assert property (s_echo_off_cmd ##0 (!s_term_taken)[*3] |=> echo_on)
    else $error("echo stopped before terminator");
  AST_ECHO_END: assert property (s_q.echo_stop ##0 s_term_taken |=> !echo_on)
    else $error("echo still on after terminator");
  AST_INST_RST: assert property (cmd_valid && cmd_op == rpc_pkg::OP_INST_RST && !rx_take
    |=> $stable(echo_on))
    else $error("instrument reset changed echo");
  AST_PROMPT: assert property (cmd_parsed && prompt_on |=> s_q.prompt_pend)
    else $error("prompt not queued after parse");
  AST_QEVT_CLR: assert property (cmd_valid && cmd_op == rpc_pkg::OP_QEVT_RD
    && (ques_cond & rpc_pkg::QEVT_LATCHED) == 16'h0000 |=> s_q.qevt == 16'h0000)
    else $error("event register not cleared by read");
  AST_LATCH: assert property ((s_q.qevt & ~rpc_pkg::QEVT_LATCHED) == 16'h0000)
    else $error("unlatched event bit held");
  AST_XOFF: assert property (pace_on && rx_near_full && !s_q.xoff_sent && !s_q.flow_pend
    |=> s_q.flow_pend && s_q.flow_char == rpc_pkg::CHR_XOFF)
    else $error("XOFF not raised at near full");
  AST_BUF: assert property (s_q.cnt <= rpc_pkg::BUF_DEPTH)
    else $error("transmit buffer overfilled");

endmodule

`default_nettype wire

// ==== test/rpc_host_model.sv ====
// Host model: sends serial characters and collects the transmitted ones
`timescale 1ns/100ps
`default_nettype none

module rpc_host (
  input  wire logic       sys_clk,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [2:0] cnt_q = 3'h0;
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  // ==========
  // Receiver side
  // A slow host takes at most one character every eight cycles, so the buffer fills and refuses
  always @(posedge sys_clk) begin
    cnt_q    <= cnt_q + 3'h1;
    tx_ready <= !slow || (cnt_q == 3'h7);
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end

  // ==========
  // Sender side
  // Held until taken; inverted afterwards so a stale character is never read
  task automatic send(input logic [7:0] c, output bit ok);
    ok = 1'b0;
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    for (int i = 0; i < 200 && !ok; i++) begin
      #1 ok = rx_ready;
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~c;
  endtask
endmodule

`default_nettype wire

// ==== test/test_rpc_core.sv ====
// Self-checking bench for the remote port command core
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (a), (b)); end end

module test_rpc_core;
  logic              sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_parsed = 1'b0;
  rpc_pkg::rpc_op_t  cmd_op = rpc_pkg::OP_QMASK_RD;
  logic [15:0]       cmd_arg = 16'h0000, ques_cond = 16'h0000, rsp_data, rd;
  logic [4:0]        saved_addr = 5'h09, bus_addr;
  logic              rx_near_full = 1'b0, tx_idle = 1'b1, slow = 1'b0;
  logic              rsp_valid, cmd_err, ques_summary, save_req, echo_on, pace_on;
  logic              prompt_on, rx_valid, rx_ready, tx_valid, tx_ready, rv, re, sv;
  logic [1:0]        rate_sel;
  logic [7:0]        rx_data, tx_data;
  logic [15:0]       bauds[4];
  int                fail_count = 0, compares = 0;
  bit                ok;

  always #2.5 sys_clk = ~sys_clk;

  rpc_core i_rpc_core (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_parsed(cmd_parsed), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_err(cmd_err), .ques_cond(ques_cond),
    .ques_summary(ques_summary), .saved_addr(saved_addr), .bus_addr(bus_addr),
    .save_req(save_req), .rate_sel(rate_sel), .echo_on(echo_on), .pace_on(pace_on),
    .prompt_on(prompt_on), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .rx_near_full(rx_near_full), .tx_idle(tx_idle), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  rpc_host i_rpc_host (.sys_clk(sys_clk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  // ==========
  // Access tasks
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Answer registered at the taking edge, so it is read just after it
  task automatic cmd(input rpc_pkg::rpc_op_t op, input logic [15:0] arg);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_arg   <= arg;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    rv = rsp_valid;
    rd = rsp_data;
    re = cmd_err;
    sv = save_req;
  endtask

  task automatic q(input rpc_pkg::rpc_op_t op, input logic [15:0] exp);
    cmd(op, 16'h0000);
    `CHK(rv, 1'b1);
    `CHK(rd, exp);
  endtask

  task automatic wr(input rpc_pkg::rpc_op_t op, input logic [15:0] arg, input logic err);
    cmd(op, arg);
    `CHK(re, err);
  endtask

  task automatic cond(input logic [15:0] v);
    @(posedge sys_clk);
    ques_cond <= v;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic snd(input logic [7:0] c);
    i_rpc_host.send(c, ok);
    if (!ok) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic take(input logic [7:0] c);
    logic [7:0] g;
    for (int i = 0; i < 300 && i_rpc_host.got.size() == 0; i++) begin
      @(posedge sys_clk);
    end
    if (i_rpc_host.got.size() == 0) begin
      fail_count++;
      wrap_up();
    end else begin
      g = i_rpc_host.got.pop_front();
      `CHK(g, c);
    end
  endtask

  task automatic quiet();
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK(i_rpc_host.got.size(), 0);
  endtask

  task automatic tend(input string name);
    $display("test %s done, %0d mismatches so far", name, fail_count);
  endtask

  // ==========
  // Tests
  initial begin
    bauds = '{rpc_pkg::BAUD_9600, rpc_pkg::BAUD_4800, rpc_pkg::BAUD_2400,
              rpc_pkg::BAUD_19200};
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(bus_addr, 5'h09);
    `CHK(rx_ready, 1'b1);
    `CHK(tx_valid, 1'b0);
    q(rpc_pkg::OP_QMASK_RD, rpc_pkg::QMASK_RST);
    q(rpc_pkg::OP_ADDR_RD, 16'h0009);
    q(rpc_pkg::OP_ECHO_RD, 16'h0000);
    q(rpc_pkg::OP_PACE_RD, 16'h0000);
    q(rpc_pkg::OP_PROMPT_RD, 16'h0000);
    tend("reset");

    wr(rpc_pkg::OP_QMASK_WR, 16'h3002, 1'b0);
    q(rpc_pkg::OP_QMASK_RD, 16'h3002);
    cond(16'h0001);
    `CHK(ques_summary, 1'b0);
    cond(16'h0002);
    `CHK(ques_summary, 1'b1);
    cond(16'h0000);
    `CHK(ques_summary, 1'b0);
    cond(16'h1000);
    cond(16'h0000);
    `CHK(ques_summary, 1'b1);
    q(rpc_pkg::OP_QEVT_RD, 16'h1000);
    q(rpc_pkg::OP_QEVT_RD, 16'h0000);
    `CHK(ques_summary, 1'b0);
    wr(rpc_pkg::OP_QMASK_WR, 16'h0FFF, 1'b0);
    cond(16'h2000);
    cond(16'h0000);
    `CHK(ques_summary, 1'b0);
    q(rpc_pkg::OP_QEVT_RD, 16'h2000);
    tend("status mask");

    wr(rpc_pkg::OP_ADDR_WR, 16'h001E, 1'b0);
    `CHK(sv, 1'b0);
    q(rpc_pkg::OP_ADDR_RD, 16'h001E);
    `CHK(bus_addr, 5'h1E);
    wr(rpc_pkg::OP_ADDR_WR, 16'h001F, 1'b1);
    q(rpc_pkg::OP_ADDR_RD, 16'h001E);
    wr(rpc_pkg::OP_ADDR_WR, 16'h0000, 1'b0);
    q(rpc_pkg::OP_ADDR_RD, 16'h0000);
    wr(rpc_pkg::OP_SAVE, 16'h0000, 1'b0);
    `CHK(sv, 1'b1);
    tend("bus address");

    for (int i = 0; i < 4; i++) begin
      wr(rpc_pkg::OP_RATE_WR, bauds[i], 1'b0);
      repeat (3) @(posedge sys_clk);
      q(rpc_pkg::OP_RATE_RD, bauds[i]);
      `CHK(rate_sel, 2'(i + 1));
    end
    wr(rpc_pkg::OP_RATE_WR, 16'h04B0, 1'b1);
    q(rpc_pkg::OP_RATE_RD, rpc_pkg::BAUD_19200);
    @(posedge sys_clk);
    tx_idle <= 1'b0;
    wr(rpc_pkg::OP_RATE_WR, rpc_pkg::BAUD_2400, 1'b0);
    repeat (5) @(posedge sys_clk);
    tx_idle <= 1'b1;
    #1;
    `CHK(rate_sel, rpc_pkg::RATE_19200);
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(rate_sel, rpc_pkg::RATE_2400);
    tend("serial rate");

    wr(rpc_pkg::OP_ECHO_WR, 16'h0001, 1'b0);
    q(rpc_pkg::OP_ECHO_RD, 16'h0001);
    `CHK(echo_on, 1'b1);
    snd(8'h41);
    take(8'h41);
    wr(rpc_pkg::OP_INST_RST, 16'h0000, 1'b0);
    q(rpc_pkg::OP_ECHO_RD, 16'h0001);
    wr(rpc_pkg::OP_ECHO_WR, 16'h0002, 1'b1);
    @(posedge sys_clk);
    slow <= 1'b1;
    // Six characters against a two-entry buffer force a stall
    for (int i = 0; i < 6; i++) begin
      snd(8'h50 + 8'(i));
    end
    for (int i = 0; i < 6; i++) begin
      take(8'h50 + 8'(i));
    end
    slow <= 1'b0;
    wr(rpc_pkg::OP_ECHO_WR, 16'h0000, 1'b0);
    snd(8'h42);
    take(8'h42);
    snd(rpc_pkg::CHR_TERM);
    take(rpc_pkg::CHR_TERM);
    q(rpc_pkg::OP_ECHO_RD, 16'h0000);
    `CHK(echo_on, 1'b0);
    snd(8'h43);
    quiet();
    tend("echo");

    wr(rpc_pkg::OP_PROMPT_WR, 16'h0001, 1'b0);
    q(rpc_pkg::OP_PROMPT_RD, 16'h0001);
    wr(rpc_pkg::OP_PROMPT_WR, 16'h0002, 1'b1);
    `CHK(prompt_on, 1'b1);
    @(posedge sys_clk);
    cmd_parsed <= 1'b1;
    @(posedge sys_clk);
    cmd_parsed <= 1'b0;
    take(rpc_pkg::CHR_PROMPT);
    quiet();
    wr(rpc_pkg::OP_PROMPT_WR, 16'h0000, 1'b0);
    q(rpc_pkg::OP_PROMPT_RD, 16'h0000);
    @(posedge sys_clk);
    cmd_parsed <= 1'b1;
    @(posedge sys_clk);
    cmd_parsed <= 1'b0;
    quiet();
    tend("prompt");

    wr(rpc_pkg::OP_PACE_WR, 16'h0001, 1'b0);
    q(rpc_pkg::OP_PACE_RD, 16'h0001);
    wr(rpc_pkg::OP_PACE_WR, 16'h0002, 1'b1);
    `CHK(pace_on, 1'b1);
    @(posedge sys_clk);
    rx_near_full <= 1'b1;
    take(rpc_pkg::CHR_XOFF);
    @(posedge sys_clk);
    rx_near_full <= 1'b0;
    take(rpc_pkg::CHR_XON);
    wr(rpc_pkg::OP_PACE_WR, 16'h0000, 1'b0);
    q(rpc_pkg::OP_PACE_RD, 16'h0000);
    @(posedge sys_clk);
    rx_near_full <= 1'b1;
    quiet();
    tend("pacing");
    wrap_up();
  end
endmodule

`default_nettype wire
